//--- verilog/stop_power_ctrl.sv
// stop mode, ring wake, power-on/brownout reset and supply warning control
`include "stop_cfg.svh"
`default_nettype none
module stop_power_ctrl
   import stop_pkg::*;
#(
   parameter int unsigned STARTUP_CLOCKS = `STARTUP_CLOCKS
) (
   input  wire logic               clock_i,
   input  wire logic               rst_i,
   input  wire logic               psel_i,
   input  wire logic               penable_i,
   input  wire logic               pwrite_i,
   input  wire logic [`ADDR_W-1:0] paddr_i,
   input  wire logic [31:0]        pwdata_i,
   output logic      [31:0]        prdata_o,
   output logic                    pready_o,
   output logic                    pslverr_o,
   input  wire logic               ext_irq_i,
   input  wire logic               rtc_irq_i,
   input  wire logic               supply_ok_i,
   input  wire logic               supply_warn_i,
   input  wire logic               other_irq_i,
   input  wire logic [15:0]        other_vector_i,
   output logic                    cpu_reset_o,
   output logic                    stop_o,
   output logic                    osc_enable_o,
   output logic                    reference_on_o,
   output logic                    ring_clock_o,
   output logic                    irq_req_o,
   output logic      [15:0]        irq_vector_o
);
   function automatic reg_sel_e reg_decode(input logic [`ADDR_W-1:0] a);
      if (a == {2'b00, `POWER_CTRL_IDX, 2'b00})
         return SEL_PC;
      else if (a == {2'b00, `EXT_FLAG_IDX, 2'b00})
         return SEL_EF;
      else if (a == {2'b00, `WD_CTRL_IDX, 2'b00})
         return SEL_WD;
      else
         return SEL_NONE;
   endfunction

   logic [3:0]  sync_s;
   logic        ext_s;
   logic        rtc_s;
   logic        ok_s;
   logic        warn_s;
   logic        cnt_start;
   logic        cnt_done;
   logic        wake;
   logic        wr_en;
   logic        running_nxt;
   logic        pf_pend;
   reg_sel_e    sel;
   logic [7:0]  rd_byte;

   pwr_state_e  state_r;
   pwr_state_e  state_nxt;
   logic        stop_req_r;
   logic        stop_req_nxt;
   logic        keep_r;
   logic        keep_nxt;
   logic        ring_sel_r;
   logic        ring_sel_nxt;
   logic        pf_en_r;
   logic        pf_en_nxt;
   logic        pf_flag_r;
   logic        pf_flag_nxt;
   logic [31:0] prdata_nxt;
   logic        pready_nxt;
   logic        pslverr_nxt;
   logic        cpu_reset_nxt;
   logic        stop_nxt;
   logic        osc_enable_nxt;
   logic        reference_on_nxt;
   logic        ring_clock_nxt;
   logic        irq_req_nxt;
   logic [15:0] irq_vector_nxt;

   sync2 #(.W(4)) u_sync (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .async_i ({supply_warn_i, supply_ok_i, rtc_irq_i, ext_irq_i}),
      .sync_o  (sync_s)
   );
   assign ext_s  = sync_s[0];
   assign rtc_s  = sync_s[1];
   assign ok_s   = sync_s[2];
   assign warn_s = sync_s[3];

   startup_counter #(.N(STARTUP_CLOCKS)) u_cnt (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .start_i (cnt_start),
      .done_o  (cnt_done)
   );

   // timer, serial and watchdog sources need clocks, so only these wake
   assign wake = ext_s | rtc_s | (pf_en_r & keep_r & warn_s);

   always_comb
   begin
      state_nxt = state_r;
      cnt_start = 1'b0;
      case (state_r)
         ST_POR_HOLD:
            if (ok_s)
            begin
               state_nxt = ST_POR_COUNT;
               cnt_start = 1'b1;
            end
         ST_POR_COUNT:
            if (!ok_s)
               state_nxt = ST_POR_HOLD;
            else if (cnt_done)
               state_nxt = ST_RUN;
         ST_RUN:
            if (!ok_s)
               state_nxt = ST_POR_HOLD;
            else if (stop_req_r)
               state_nxt = ST_STOP;
         ST_STOP:
            // with the reference off the monitor is blind, so no reset here
            if (keep_r && !ok_s)
               state_nxt = ST_POR_HOLD;
            else if (wake)
            begin
               cnt_start = 1'b1;
               state_nxt = ring_sel_r ? ST_RING : ST_WARM;
            end
         ST_WARM:
            if (!ok_s)
               state_nxt = ST_POR_HOLD;
            else if (cnt_done)
               state_nxt = ST_RUN;
         ST_RING:
            if (!ok_s)
               state_nxt = ST_POR_HOLD;
            else if (stop_req_r)
               state_nxt = ST_STOP;
            else if (cnt_done)
               state_nxt = ST_RUN;
         default:
            state_nxt = ST_POR_HOLD;
      endcase
   end

   assign sel   = reg_decode(paddr_i);
   assign wr_en = psel_i && penable_i && pwrite_i && pready_o;

   always_comb
   begin
      stop_req_nxt = stop_req_r;
      keep_nxt     = keep_r;
      ring_sel_nxt = ring_sel_r;
      pf_en_nxt    = pf_en_r;
      pf_flag_nxt  = pf_flag_r;
      if (wr_en && sel == SEL_PC)
         stop_req_nxt = pwdata_i[`STOP_BIT];
      if (wr_en && sel == SEL_EF)
      begin
         keep_nxt     = pwdata_i[`KEEP_BIT];
         ring_sel_nxt = pwdata_i[`RING_SEL_BIT];
      end
      if (wr_en && sel == SEL_WD)
      begin
         pf_en_nxt   = pwdata_i[`PF_EN_BIT];
         pf_flag_nxt = pwdata_i[`PF_FLAG_BIT];
      end
      // detection after the write so a warning never loses to a clear
      if (warn_s && ok_s && (state_r != ST_STOP || keep_r))
         pf_flag_nxt = 1'b1;
      if (state_r == ST_STOP && state_nxt != ST_STOP)
         stop_req_nxt = 1'b0;
      if (state_nxt == ST_POR_HOLD || state_r == ST_POR_HOLD)
      begin
         stop_req_nxt = `STOP_RST;
         keep_nxt     = `KEEP_RST;
         ring_sel_nxt = `RING_SEL_RST;
         pf_en_nxt    = `PF_EN_RST;
         pf_flag_nxt  = `PF_FLAG_RST;
      end
   end

   always_comb
   begin
      rd_byte = 8'h00;
      case (sel)
         SEL_PC:
            rd_byte[`STOP_BIT] = stop_req_r;
         SEL_EF:
         begin
            rd_byte[`KEEP_BIT]     = keep_r;
            rd_byte[`RING_SEL_BIT] = ring_sel_r;
            rd_byte[`RING_ACT_BIT] = ring_clock_o;
         end
         SEL_WD:
         begin
            rd_byte[`PF_EN_BIT]   = pf_en_r;
            rd_byte[`PF_FLAG_BIT] = pf_flag_r;
         end
         default:
            rd_byte = 8'h00;
      endcase
      // answer lands one cycle after setup: a single-cycle access phase
      pready_nxt  = psel_i && !penable_i;
      pslverr_nxt = psel_i && !penable_i && (sel == SEL_NONE);
      prdata_nxt  = (psel_i && !penable_i && !pwrite_i) ?
                    {24'h000000, rd_byte} : 32'h00000000;
   end

   always_comb
   begin
      running_nxt      = (state_nxt == ST_RUN) || (state_nxt == ST_RING);
      pf_pend          = pf_en_nxt && pf_flag_nxt;
      cpu_reset_nxt    = (state_nxt == ST_POR_HOLD) ||
                         (state_nxt == ST_POR_COUNT);
      stop_nxt         = (state_nxt == ST_STOP);
      osc_enable_nxt   = !stop_nxt && (state_nxt != ST_POR_HOLD);
      reference_on_nxt = !stop_nxt || keep_nxt;
      ring_clock_nxt   = (state_nxt == ST_RING);
      irq_req_nxt      = running_nxt && (pf_pend || other_irq_i);
      irq_vector_nxt   = pf_pend ? `PF_VECTOR : other_vector_i;
   end

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_r        <= ST_POR_HOLD;
         stop_req_r     <= `STOP_RST;
         keep_r         <= `KEEP_RST;
         ring_sel_r     <= `RING_SEL_RST;
         pf_en_r        <= `PF_EN_RST;
         pf_flag_r      <= `PF_FLAG_RST;
         prdata_o       <= 32'h00000000;
         pready_o       <= 1'b0;
         pslverr_o      <= 1'b0;
         cpu_reset_o    <= 1'b1;
         stop_o         <= 1'b0;
         osc_enable_o   <= 1'b0;
         reference_on_o <= 1'b1;
         ring_clock_o   <= 1'b0;
         irq_req_o      <= 1'b0;
         irq_vector_o   <= 16'h0000;
      end
      else
      begin
         state_r        <= state_nxt;
         stop_req_r     <= stop_req_nxt;
         keep_r         <= keep_nxt;
         ring_sel_r     <= ring_sel_nxt;
         pf_en_r        <= pf_en_nxt;
         pf_flag_r      <= pf_flag_nxt;
         prdata_o       <= prdata_nxt;
         pready_o       <= pready_nxt;
         pslverr_o      <= pslverr_nxt;
         cpu_reset_o    <= cpu_reset_nxt;
         stop_o         <= stop_nxt;
         osc_enable_o   <= osc_enable_nxt;
         reference_on_o <= reference_on_nxt;
         ring_clock_o   <= ring_clock_nxt;
         irq_req_o      <= irq_req_nxt;
         irq_vector_o   <= irq_vector_nxt;
      end
   end

   // helper lengths for the start-up intervals
   int ring_len_r;
   int por_len_r;
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ring_len_r <= 0;
         por_len_r  <= 0;
      end
      else
      begin
         ring_len_r <= ring_clock_o ? ring_len_r + 1 : 0;
         por_len_r  <= (state_r == ST_POR_COUNT) ? por_len_r + 1 : 0;
      end
   end

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   sequence pf_enable_write;
      psel_i && !penable_i && pwrite_i && reg_decode(paddr_i) == SEL_WD
      && pwdata_i[`PF_EN_BIT] ##1 psel_i && penable_i && state_r == ST_RUN
      && ok_s;
   endsequence

   sequence stop_wake_seen;
      state_r == ST_STOP && wake && !(keep_r && !ok_s);
   endsequence

   stop_entry_a: assert property (state_r == ST_RUN && ok_s && stop_req_r
      |=> stop_o && !osc_enable_o && state_r == ST_STOP)
      else $error("stop request did not halt clocks");
   stop_wake_a: assert property (stop_wake_seen
      |=> !stop_o ##1 !stop_o)
      else $error("wake did not end stop");
   rtc_wake_a: assert property (state_r == ST_STOP && rtc_s
      |=> state_r != ST_STOP)
      else $error("clock interrupt did not wake");
   ref_stop_a: assert property (stop_o |-> reference_on_o == keep_r)
      else $error("reference wrong during stop");
   ref_full_a: assert property (!stop_o && !cpu_reset_o
      |-> reference_on_o)
      else $error("reference off outside stop");
   stop_reset_a: assert property (state_r == ST_STOP && keep_r && !ok_s
      |=> cpu_reset_o && !stop_o)
      else $error("supply reset did not end stop");
   ring_wake_a: assert property (stop_wake_seen and ring_sel_r
      |=> ring_clock_o && !cpu_reset_o)
      else $error("ring wake did not start ring");
   plain_wake_a: assert property (stop_wake_seen and !ring_sel_r
      |=> !ring_clock_o [*2])
      else $error("plain wake used ring");
   ring_length_a: assert property ($fell(ring_clock_o) && state_r == ST_RUN
      |-> ring_len_r == STARTUP_CLOCKS)
      else $error("ring interval length wrong");
   ring_flag_a: assert property (psel_i && !penable_i && !pwrite_i
      && reg_decode(paddr_i) == SEL_EF
      |=> prdata_o[`RING_ACT_BIT] == $past(ring_clock_o))
      else $error("ring flag misreads clock source");
   por_length_a: assert property ($fell(cpu_reset_o)
      |-> por_len_r == STARTUP_CLOCKS)
      else $error("power-on interval length wrong");
   brownout_a: assert property (!ok_s && state_r != ST_STOP
      |=> cpu_reset_o [*2])
      else $error("low supply not held in reset");
   pf_vector_a: assert property (pf_en_r && pf_flag_r && ok_s
      && state_r == ST_RUN && !stop_req_r && !wr_en
      |=> irq_req_o && irq_vector_o == `PF_VECTOR)
      else $error("warning did not vector");
   pf_first_a: assert property (pf_en_r && pf_flag_r && other_irq_i
      && irq_req_o |-> irq_vector_o == `PF_VECTOR)
      else $error("warning lost priority");
   pf_enable_a: assert property (pf_enable_write |=> pf_en_r)
      else $error("enable write ignored");
   pf_flag_a: assert property (warn_s && ok_s && state_r == ST_RUN
      |=> pf_flag_r)
      else $error("warning flag not set");
   pf_stop_a: assert property (state_r == ST_STOP && pf_en_r && keep_r
      && warn_s && ok_s |=> !stop_o)
      else $error("warning did not wake stop");
   wake_clear_a: assert property ($fell(stop_o) |-> !stop_req_r)
      else $error("stop bit survived wake");
endmodule
`default_nettype wire

//--- verilog/stop_cfg.svh
// offsets, bit positions, reset values and counts of the stop/supply block
`ifndef STOP_CFG_SVH
`define STOP_CFG_SVH

`define ADDR_W           12
`define POWER_CTRL_IDX   8'h87
`define EXT_FLAG_IDX     8'h91
`define WD_CTRL_IDX      8'hD8

`define STOP_BIT         1
`define KEEP_BIT         0
`define RING_SEL_BIT     1
`define RING_ACT_BIT     2
`define PF_FLAG_BIT      4
`define PF_EN_BIT        5

`define STOP_RST         1'b0
`define KEEP_RST         1'b0
`define RING_SEL_RST     1'b0
`define PF_EN_RST        1'b0
`define PF_FLAG_RST      1'b0

`define PF_VECTOR        16'h0033
`define STARTUP_CLOCKS   65536

`endif

//--- verilog/stop_pkg.sv
// types shared by the stop/supply control block
`default_nettype none
package stop_pkg;

   typedef enum logic [5:0]
   {
      ST_POR_HOLD  = 6'b000001,
      ST_POR_COUNT = 6'b000010,
      ST_RUN       = 6'b000100,
      ST_STOP      = 6'b001000,
      ST_WARM      = 6'b010000,
      ST_RING      = 6'b100000
   } pwr_state_e;

   typedef enum logic [1:0]
   {
      SEL_NONE = 2'b00,
      SEL_PC   = 2'b01,
      SEL_EF   = 2'b10,
      SEL_WD   = 2'b11
   } reg_sel_e;

endpackage
`default_nettype wire

//--- verilog/sync2.sv
// two-flop synchroniser for a group of independent levels
`default_nettype none
module sync2 #(
   parameter int W = 4
) (
   input  wire logic         clock_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   logic [W-1:0] meta_r;
   logic [W-1:0] hold_r;

   genvar g;
   generate
      for (g = 0; g < W; g++)
      begin : g_bit
         always_ff @(posedge clock_i or posedge rst_i)
         begin
            if (rst_i)
            begin
               meta_r[g] <= 1'b0;
               hold_r[g] <= 1'b0;
            end
            else
            begin
               meta_r[g] <= async_i[g];
               hold_r[g] <= meta_r[g];
            end
         end
      end
   endgenerate

   assign sync_o = hold_r;
endmodule
`default_nettype wire

//--- verilog/startup_counter.sv
// counts crystal clocks for oscillator start-up; done is a one-cycle level
`include "stop_cfg.svh"
`default_nettype none
module startup_counter #(
   parameter int unsigned N = `STARTUP_CLOCKS
) (
   input  wire logic clock_i,
   input  wire logic rst_i,
   input  wire logic start_i,
   output logic      done_o
);
   localparam int CW = $clog2(N + 1);
   localparam logic [CW-1:0] LAST = CW'(N - 1);

   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic          run_r;
   logic          run_nxt;

   // done is combinational so the owner changes state on exactly the Nth edge
   assign done_o = run_r && (cnt_r == LAST);

   always_comb
   begin
      cnt_nxt = cnt_r;
      run_nxt = run_r;
      if (start_i)
      begin
         cnt_nxt = '0;
         run_nxt = 1'b1;
      end
      else if (done_o)
         run_nxt = 1'b0;
      else if (run_r)
         cnt_nxt = cnt_r + CW'(1);
   end

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cnt_r <= '0;
         run_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         run_r <= run_nxt;
      end
   end
endmodule
`default_nettype wire

//--- bench/stop_power_ctrl_tb.sv
// self-checking bench for the stop mode and supply monitor control block
`include "stop_cfg.svh"
`default_nettype none
module stop_power_ctrl_tb;
   import stop_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   // short start-up count keeps the run brief; all start-up and ring spans derive from it
   localparam int S = 8;
   localparam logic [11:0] PC_A = {2'b00, `POWER_CTRL_IDX, 2'b00};
   localparam logic [11:0] EF_A = {2'b00, `EXT_FLAG_IDX, 2'b00};
   localparam logic [11:0] WD_A = {2'b00, `WD_CTRL_IDX, 2'b00};
   localparam logic [31:0] STOP = 32'h1 << `STOP_BIT;
   localparam logic [31:0] KEEP = 32'h1 << `KEEP_BIT;
   localparam logic [31:0] RSEL = 32'h1 << `RING_SEL_BIT;
   localparam logic [31:0] RACT = 32'h1 << `RING_ACT_BIT;
   localparam logic [31:0] PFF  = 32'h1 << `PF_FLAG_BIT;
   localparam logic [31:0] PFEN = 32'h1 << `PF_EN_BIT;

   logic        clock_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        psel_i = 1'b0;
   logic        penable_i = 1'b0;
   logic        pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0000_0000;
   logic [31:0] prdata_o;
   logic        pready_o;
   logic        pslverr_o;
   logic        ext_irq_i = 1'b0;
   logic        rtc_irq_i = 1'b0;
   logic        supply_ok_i = 1'b0;
   logic        supply_warn_i = 1'b0;
   logic        other_irq_i = 1'b0;
   logic [15:0] other_vector_i = 16'h0000;
   logic        cpu_reset_o;
   logic        stop_o;
   logic        osc_enable_o;
   logic        reference_on_o;
   logic        ring_clock_o;
   logic        irq_req_o;
   logic [15:0] irq_vector_o;
   int          error_cnt = 0;
   int          checks = 0;
   int          cyc = 0;
   int          t0;
   logic [31:0] d;
   logic        e;

   stop_power_ctrl #(.STARTUP_CLOCKS(S)) u_stop_power_ctrl (
      .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .ext_irq_i(ext_irq_i), .rtc_irq_i(rtc_irq_i),
      .supply_ok_i(supply_ok_i), .supply_warn_i(supply_warn_i),
      .other_irq_i(other_irq_i), .other_vector_i(other_vector_i),
      .cpu_reset_o(cpu_reset_o), .stop_o(stop_o),
      .osc_enable_o(osc_enable_o), .reference_on_o(reference_on_o),
      .ring_clock_o(ring_clock_o), .irq_req_o(irq_req_o),
      .irq_vector_o(irq_vector_o));

   always #25 clock_i = ~clock_i;

   always @(posedge clock_i)
      cyc <= cyc + 1;

   task automatic chk_bit(input string n, input logic x, input logic g);
      checks++;
      if (g !== x)
      begin
         error_cnt++;
         $display("wrong value %s expected %b seen %b", n, x, g);
      end
   endtask

   task automatic chk_word(input string n, input logic [31:0] x,
                           input logic [31:0] g);
      checks++;
      if (g !== x)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, x, g);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      @(posedge clock_i);
      psel_i   <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i  <= a;
      pwdata_i <= wd;
      @(posedge clock_i);
      penable_i <= 1'b1;
      // waits for pready_o; only the watchdog ends a wait that never sees it
      do
         @(posedge clock_i);
      while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] wd);
      logic [31:0] r;
      logic        x;
      apb(1'b1, a, wd, r, x);
   endtask

   function automatic logic outv(input int k);
      case (k)
         0: return stop_o;
         1: return cpu_reset_o;
         default: return ring_clock_o;
      endcase
   endfunction

   // bounded wait on an output level; running out counts as a mismatch
   task automatic wait_out(input string n, input int k, input logic v,
                           input int lim);
      int c;
      c = 0;
      while (outv(k) !== v && c < lim)
      begin
         @(posedge clock_i);
         c++;
      end
      chk_bit(n, v, outv(k));
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clock_i);
      error_cnt++;
      $display("wrong value watchdog expected finish seen hang");
      final_report();
   end

   initial
   begin
      repeat (12) @(posedge clock_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clock_i);
      chk_bit("cpu_reset_o", 1'b1, cpu_reset_o);
      supply_ok_i <= 1'b1;
      t0 = cyc;
      wait_out("cpu_reset_o", 1, 1'b0, S + 20);
      // two sync edges, one decode edge, S counted, one sampling edge
      chk_word("startup span", 32'(S + 4), 32'(cyc - t0));
      chk_bit("osc_enable_o", 1'b1, osc_enable_o);
      apb(1'b0, PC_A, 32'h0, d, e);
      chk_word("power_control_reg", 32'h0, d);
      apb(1'b0, EF_A, 32'h0, d, e);
      chk_word("extended_flag_reg", 32'h0, d);
      apb(1'b0, WD_A, 32'h0, d, e);
      chk_word("watchdog_control_reg", 32'h0, d);
      apb(1'b0, 12'h000, 32'h0, d, e);
      chk_bit("pslverr_o", 1'b1, e);
      chk_word("unmapped read", 32'h0, d);
      $display("test power-up done");

      // keep bit must not touch the reference at full power
      wr(EF_A, KEEP);
      chk_bit("reference_on_o", 1'b1, reference_on_o);
      wr(EF_A, 32'h0);
      repeat (2) @(posedge clock_i);
      chk_bit("reference_on_o", 1'b1, reference_on_o);
      $display("test reference at full power done");

      wr(PC_A, STOP);
      wait_out("stop_o", 0, 1'b1, 10);
      chk_bit("osc_enable_o", 1'b0, osc_enable_o);
      chk_bit("reference_on_o", 1'b0, reference_on_o);
      other_irq_i <= 1'b1;
      repeat (6) @(posedge clock_i);
      chk_bit("stop_o", 1'b1, stop_o);
      other_irq_i <= 1'b0;
      ext_irq_i <= 1'b1;
      wait_out("stop_o", 0, 1'b0, 10);
      chk_bit("ring_clock_o", 1'b0, ring_clock_o);
      ext_irq_i <= 1'b0;
      apb(1'b0, PC_A, 32'h0, d, e);
      chk_word("power_control_reg", 32'h0, d);
      repeat (S + 4) @(posedge clock_i);
      $display("test plain stop done");

      wr(EF_A, KEEP | RSEL);
      wr(PC_A, STOP);
      wait_out("stop_o", 0, 1'b1, 10);
      chk_bit("reference_on_o", 1'b1, reference_on_o);
      rtc_irq_i <= 1'b1;
      wait_out("stop_o", 0, 1'b0, 10);
      t0 = cyc;
      chk_bit("ring_clock_o", 1'b1, ring_clock_o);
      rtc_irq_i <= 1'b0;
      apb(1'b0, EF_A, 32'h0, d, e);
      chk_word("extended_flag_reg", KEEP | RSEL | RACT, d);
      wait_out("ring_clock_o", 2, 1'b0, S + 10);
      chk_word("ring span", 32'(S), 32'(cyc - t0));
      apb(1'b0, EF_A, 32'h0, d, e);
      chk_word("extended_flag_reg", KEEP | RSEL, d);
      $display("test ring wake done");

      supply_warn_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      apb(1'b0, WD_A, 32'h0, d, e);
      chk_word("watchdog_control_reg", PFF, d);
      chk_bit("irq_req_o", 1'b0, irq_req_o);
      supply_warn_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      wr(WD_A, 32'h0);
      apb(1'b0, WD_A, 32'h0, d, e);
      chk_word("watchdog_control_reg", 32'h0, d);
      wr(WD_A, PFEN);
      other_irq_i <= 1'b1;
      other_vector_i <= 16'h0003;
      supply_warn_i <= 1'b1;
      repeat (5) @(posedge clock_i);
      chk_bit("irq_req_o", 1'b1, irq_req_o);
      chk_word("irq_vector_o", 32'(`PF_VECTOR), 32'(irq_vector_o));
      other_irq_i <= 1'b0;
      supply_warn_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      wr(WD_A, PFEN);
      wr(PC_A, STOP);
      wait_out("stop_o", 0, 1'b1, 10);
      supply_warn_i <= 1'b1;
      wait_out("stop_o", 0, 1'b0, 10);
      supply_warn_i <= 1'b0;
      // no timing-sensitive step while the ring still clocks the cpu
      wait_out("ring_clock_o", 2, 1'b0, S + 10);
      $display("test supply warning done");

      wr(WD_A, 32'h0);
      wr(PC_A, STOP);
      wait_out("stop_o", 0, 1'b1, 10);
      supply_ok_i <= 1'b0;
      wait_out("stop_o", 0, 1'b0, 10);
      chk_bit("cpu_reset_o", 1'b1, cpu_reset_o);
      repeat (S + 4) @(posedge clock_i);
      chk_bit("cpu_reset_o", 1'b1, cpu_reset_o);
      supply_ok_i <= 1'b1;
      wait_out("cpu_reset_o", 1, 1'b0, S + 20);
      apb(1'b0, EF_A, 32'h0, d, e);
      chk_word("extended_flag_reg", 32'h0, d);
      $display("test brownout in stop done");
      final_report();
   end
endmodule
`default_nettype wire
